// >>> inc/eth_mon_pkg.sv
// Contract
// - read-only word at 0x00 holds the expected packet total
// - read-only word at 0x04 counts packets received without error
// - read-only word at 0x08 counts packets received with error
// - 64-bit received byte count, low word 0x0C, high word 0x10
// - low-half read then high-half read returns one consistent 64-bit value
// - 64-bit receive cycle count, low word 0x14, high word 0x18
// - writing 1 to control bit 0 starts reception; bit self-clears once started
// - writing 1 to control bit 1 halts reception; cleared at each new start
// - read-only control bit 2 sets when received count equals expected total
// - read-only control bit 3 sets when the current packet has a CRC error
// - control bits 9 to 4 show the MAC receive-error vector
// - one active-low reset clears every counter and status bit
// - cycle counter counts periods of the 100 MHz system clock
// - cycle counter starts after the first packet ends and stops at last expected packet
package eth_mon_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFS_EXPECTED = 8'h00;
  localparam logic [7:0] OFS_GOOD = 8'h04;
  localparam logic [7:0] OFS_BAD = 8'h08;
  localparam logic [7:0] OFS_OCT_LO = 8'h0C;
  localparam logic [7:0] OFS_OCT_HI = 8'h10;
  localparam logic [7:0] OFS_DUR_LO = 8'h14;
  localparam logic [7:0] OFS_DUR_HI = 8'h18;
  localparam logic [7:0] OFS_CTRL = 8'h1C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h24;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h28;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  // ****************************************
  // control word fields
  // ****************************************
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int CTRL_DONE_BIT = 2;
  localparam int CTRL_CRC_BIT = 3;
  localparam int CTRL_ERR_LSB = 4;
  localparam int ERR_W = 6;
  // ****************************************
  // interrupt events
  // ****************************************
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_BAD_BIT = 1;
  localparam int IRQ_CRC_BIT = 2;
  // ****************************************
  // stream and timing
  // ****************************************
  localparam int CRC_ERR_BIT = 1;
  localparam logic [2:0] BEAT_BYTES = 3'h4;
  localparam longint SYS_CLK_HZ = 100_000_000;
  localparam logic [63:0] CYCLE_STEP = 64'h1;
  typedef enum logic [1:0] {PH_IDLE, PH_CLEAR, PH_RUN} rx_phase_t;
  typedef struct packed {
    logic valid;
    logic sop;
    logic eop;
    logic [1:0] empty;
    logic [ERR_W-1:0] err;
    logic [31:0] data;
  } rx_beat_t;
  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;
  typedef struct packed {
    logic good;
    logic bad;
    logic crc;
    logic [ERR_W-1:0] err;
    logic octet_inc;
    logic [2:0] octets;
  } verdict_t;
endpackage

// >>> rtl/wide_tally.sv
`timescale 1ns/100ps
`default_nettype none
module wide_tally (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  input wire logic inc,
  input wire logic [2:0] amount,
  output logic [63:0] value
);
  typedef struct packed {
    logic [63:0] cnt;
  } tally_state_t;
  tally_state_t s_q;
  tally_state_t s_d;
  // ****************************************
  // counter
  // ****************************************
  always_comb begin
    s_d = s_q;
    if (clr) begin
      s_d.cnt = 64'h0;
    end else if (inc) begin
      s_d.cnt = s_q.cnt + {61'h0, amount};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign value = s_q.cnt;
endmodule
`default_nettype wire

// >>> rtl/frame_judge.sv
`timescale 1ns/100ps
`default_nettype none
module frame_judge (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic active,
  input wire eth_mon_pkg::rx_beat_t beat,
  output eth_mon_pkg::verdict_t verdict
);
  eth_mon_pkg::verdict_t s_q;
  eth_mon_pkg::verdict_t s_d;
  localparam int ERR_W_L = eth_mon_pkg::ERR_W;
  logic [ERR_W_L-1:0] err_now;
  // ****************************************
  // end of packet evaluation
  // ****************************************
  always_comb begin
    err_now = beat.err;
    s_d = '0;
    s_d.crc = s_q.crc;
    s_d.err = s_q.err;
    if (active && beat.valid) begin
      s_d.octet_inc = 1'b1;
      s_d.octets = beat.eop ? (eth_mon_pkg::BEAT_BYTES - {1'b0, beat.empty}) : eth_mon_pkg::BEAT_BYTES;
      if (beat.eop) begin
        s_d.crc = err_now[eth_mon_pkg::CRC_ERR_BIT];
        s_d.err = err_now;
        s_d.bad = (err_now != '0);
        s_d.good = (err_now == '0);
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign verdict = s_q;
endmodule
`default_nettype wire

// >>> rtl/eth_packet_monitor.sv
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module eth_packet_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire eth_mon_pkg::apb_req_t apb_req,
  output eth_mon_pkg::apb_rsp_t apb_rsp,
  input wire eth_mon_pkg::rx_beat_t rx_beat,
  output logic rx_ready,
  input wire logic [31:0] expected_total,
  output logic irq
);
  localparam int EW = eth_mon_pkg::ERR_W;
  localparam int IW = eth_mon_pkg::IRQ_W;
  typedef struct packed {
    eth_mon_pkg::rx_phase_t phase;
    logic start;
    logic stop;
    logic done;
    logic seen_first;
    logic crc_flag;
    logic [EW-1:0] err_vec;
    logic [31:0] expected;
    logic [31:0] good;
    logic [31:0] bad;
    logic [31:0] oct_hi_shadow;
    logic [31:0] dur_hi_shadow;
    logic [IW-1:0] irq_status;
    logic [IW-1:0] irq_enable;
    logic irq;
    logic ready;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } mon_state_t;
  mon_state_t s_q;
  mon_state_t s_d;
  eth_mon_pkg::verdict_t verdict;
  logic [63:0] octet_count;
  logic [63:0] cycle_count;
  logic counters_clr;
  logic cycle_inc;
  logic running;
  logic access_first;
  logic access_done;
  logic wr_take;
  logic [31:0] ctrl_word;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [31:0] seen_total;
  logic [IW-1:0] irq_events;
  // ****************************************
  // datapath instances
  // ****************************************
  assign running = (s_q.phase == eth_mon_pkg::PH_RUN);
  assign counters_clr = (s_q.phase == eth_mon_pkg::PH_CLEAR);
  // count from end of first packet to done
  assign cycle_inc = running && s_q.seen_first;
  frame_judge judge_u (
    .pclk(pclk),
    .presetn(presetn),
    .active(running),
    .beat(rx_beat),
    .verdict(verdict)
  );
  wide_tally octet_u (
    .pclk(pclk),
    .presetn(presetn),
    .clr(counters_clr),
    .inc(verdict.octet_inc && running),
    .amount(verdict.octets),
    .value(octet_count)
  );
  wide_tally cycle_u (
    .pclk(pclk),
    .presetn(presetn),
    .clr(counters_clr),
    .inc(cycle_inc),
    .amount(eth_mon_pkg::CYCLE_STEP[2:0]),
    .value(cycle_count)
  );
  // ****************************************
  // register read mux
  // ****************************************
  // upper control bits zero
  // flags kept here so that a new start can clear them
  assign ctrl_word = {22'h0, s_q.err_vec, s_q.crc_flag, s_q.done, s_q.stop, s_q.start};
  assign access_first = apb_req.psel && apb_req.penable && !s_q.pready;
  assign access_done = apb_req.psel && apb_req.penable && s_q.pready;
  assign wr_take = access_done && apb_req.pwrite;
  assign seen_total = s_q.good + s_q.bad + 32'h1;
  always_comb begin
    rd_hit = 1'b1;
    case (apb_req.paddr)
      eth_mon_pkg::OFS_EXPECTED: rd_word = s_q.expected;
      eth_mon_pkg::OFS_GOOD: rd_word = s_q.good;
      eth_mon_pkg::OFS_BAD: rd_word = s_q.bad;
      eth_mon_pkg::OFS_OCT_LO: rd_word = octet_count[31:0];
      eth_mon_pkg::OFS_OCT_HI: rd_word = s_q.oct_hi_shadow;
      eth_mon_pkg::OFS_DUR_LO: rd_word = cycle_count[31:0];
      eth_mon_pkg::OFS_DUR_HI: rd_word = s_q.dur_hi_shadow;
      eth_mon_pkg::OFS_CTRL: rd_word = ctrl_word;
      eth_mon_pkg::OFS_IRQ_STATUS: rd_word = {29'h0, s_q.irq_status};
      eth_mon_pkg::OFS_IRQ_CLEAR: rd_word = eth_mon_pkg::RESET_WORD;
      eth_mon_pkg::OFS_IRQ_ENABLE: rd_word = {29'h0, s_q.irq_enable};
      default: begin
        rd_word = eth_mon_pkg::RESET_WORD;
        rd_hit = 1'b0;
      end
    endcase
  end
  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    irq_events = '0;
    s_d.ready = 1'b1;
    s_d.expected = expected_total;
    // apb: one wait state, pready registered
    s_d.pready = access_first;
    if (access_first) begin
      s_d.prdata = apb_req.pwrite ? eth_mon_pkg::RESET_WORD : rd_word;
      s_d.pslverr = !rd_hit;
      // snapshot high halves on low read
      if (!apb_req.pwrite && apb_req.paddr == eth_mon_pkg::OFS_OCT_LO) begin
        s_d.oct_hi_shadow = octet_count[63:32];
      end
      if (!apb_req.pwrite && apb_req.paddr == eth_mon_pkg::OFS_DUR_LO) begin
        s_d.dur_hi_shadow = cycle_count[63:32];
      end
    end else begin
      s_d.pslverr = 1'b0;
    end
    // reception phase machine
    case (s_q.phase)
      eth_mon_pkg::PH_IDLE: begin
        if (s_q.start) begin
          s_d.phase = eth_mon_pkg::PH_CLEAR;
        end
      end
      eth_mon_pkg::PH_CLEAR: begin
        s_d.good = '0;
        s_d.bad = '0;
        s_d.done = 1'b0;
        s_d.seen_first = 1'b0;
        s_d.crc_flag = 1'b0;
        s_d.err_vec = '0;
        s_d.start = 1'b0;
        s_d.stop = 1'b0;
        s_d.phase = eth_mon_pkg::PH_RUN;
      end
      eth_mon_pkg::PH_RUN: begin
        if (verdict.good || verdict.bad) begin
          s_d.seen_first = 1'b1;
          s_d.crc_flag = verdict.crc;
          s_d.err_vec = verdict.err;
          if (verdict.good) begin
            s_d.good = s_q.good + 32'h1;
          end
          if (verdict.bad) begin
            s_d.bad = s_q.bad + 32'h1;
            irq_events[eth_mon_pkg::IRQ_BAD_BIT] = 1'b1;
          end
          irq_events[eth_mon_pkg::IRQ_CRC_BIT] = verdict.crc;
          // last packet stops the clock count
          if (seen_total == s_q.expected) begin
            s_d.done = 1'b1;
            s_d.phase = eth_mon_pkg::PH_IDLE;
            irq_events[eth_mon_pkg::IRQ_DONE_BIT] = 1'b1;
          end
        end
        if (s_q.stop) begin
          s_d.phase = eth_mon_pkg::PH_IDLE;
        end
      end
      default: s_d.phase = eth_mon_pkg::PH_IDLE;
    endcase
    // register writes land at the completing edge
    if (wr_take) begin
      case (apb_req.paddr)
        eth_mon_pkg::OFS_CTRL: begin
          if (apb_req.pwdata[eth_mon_pkg::CTRL_START_BIT]) begin
            s_d.start = 1'b1;
          end
          if (apb_req.pwdata[eth_mon_pkg::CTRL_STOP_BIT]) begin
            s_d.stop = 1'b1;
          end
        end
        eth_mon_pkg::OFS_IRQ_CLEAR: s_d.irq_status = s_d.irq_status & ~apb_req.pwdata[IW-1:0];
        eth_mon_pkg::OFS_IRQ_ENABLE: s_d.irq_enable = apb_req.pwdata[IW-1:0];
        default: s_d.irq_enable = s_d.irq_enable;
      endcase
    end
    // set wins over a clear in the same cycle
    s_d.irq_status = s_d.irq_status | irq_events;
    s_d.irq = |(s_d.irq_status & s_d.irq_enable);
  end
  // ****************************************
  // state register
  // ****************************************
  // everything zero at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign apb_rsp = {s_q.prdata, s_q.pready, s_q.pslverr};
  assign rx_ready = s_q.ready;
  assign irq = s_q.irq;
endmodule
`default_nettype wire

// >>> verif/eth_mon_chk.sv
`timescale 1ns/100ps
`default_nettype none
module eth_mon_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire eth_mon_pkg::apb_req_t apb_req,
  input wire eth_mon_pkg::apb_rsp_t apb_rsp,
  input wire eth_mon_pkg::rx_beat_t rx_beat,
  input wire logic rx_ready,
  input wire logic [31:0] expected_total,
  input wire logic irq
);
  // ********
  // bus and stream checks
  // ********
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = apb_req.psel && apb_req.penable;
  wire logic rd = acc && !apb_req.pwrite && apb_rsp.pready;
  AST_ONE_WAIT: assert property (acc && !apb_rsp.pready |=> apb_rsp.pready)
    else $error("no answer after one wait state");
  AST_READY_PULSE: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready held too long");
  AST_READY_IN_ACCESS: assert property (apb_rsp.pready |-> acc)
    else $error("ready outside access phase");
  AST_MAPPED_OK: assert property (apb_rsp.pready && apb_req.paddr <= 8'h28 |-> !apb_rsp.pslverr)
    else $error("error on mapped register");
  AST_UNMAPPED_ERR: assert property (rd && apb_req.paddr > 8'h28 |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
    else $error("unmapped read not refused");
  AST_CTRL_RESERVED: assert property (rd && apb_req.paddr == 8'h1C |-> apb_rsp.prdata[31:10] == 22'h0)
    else $error("reserved control bits not zero");
  AST_NO_STALL: assert property ($past(presetn) |-> rx_ready)
    else $error("stream stalled");
  AST_RESET_QUIET: assert property ($rose(presetn) |-> !irq && !apb_rsp.pready)
    else $error("outputs active at reset release");
  cover property (acc && apb_rsp.pready && apb_req.pwrite);
  cover property (rx_beat.valid && rx_beat.eop && rx_beat.err != 6'h0);
  cover property ($rose(irq));
endmodule
bind eth_packet_monitor eth_mon_chk chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .rx_beat(rx_beat), .rx_ready(rx_ready), .expected_total(expected_total), .irq(irq));
`default_nettype wire

// >>> verif/rx_source.sv
`timescale 1ns/100ps
`default_nettype none
module rx_source (
  input wire logic pclk,
  input wire logic rx_ready,
  output var eth_mon_pkg::rx_beat_t beat
);
  // ********
  // receive stream source
  // ********
  initial beat = '0;
  task automatic send(input int n, input logic [1:0] e, input logic [5:0] er);
    for (int i = 0; i < n; i++) begin
      beat <= '{1'b1, i == 0, i == n - 1, i == n - 1 ? e : 2'h0, i == n - 1 ? er : 6'h0, $urandom};
      @(posedge pclk);
      // beat held until taken
      while (rx_ready !== 1'b1) @(posedge pclk);
    end
  endtask
  // released data shows the inverse so a stale value never looks valid
  task automatic idle;
    beat <= '{1'b0, 1'b0, 1'b0, 2'h0, 6'h0, ~beat.data};
  endtask
endmodule
`default_nettype wire

// >>> verif/ethernet_packet_monitor_bench.sv
`timescale 1ns/100ps
`default_nettype none
module ethernet_packet_monitor_bench;
  logic pclk, presetn, irq, rx_ready;
  eth_mon_pkg::apb_req_t req;
  eth_mon_pkg::apb_rsp_t rsp;
  eth_mon_pkg::rx_beat_t beat;
  logic [31:0] total, octs;
  logic [63:0] expq[$];
  int mismatches, checked, n, b, e;
  eth_packet_monitor dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .rx_beat(beat),
    .rx_ready(rx_ready), .expected_total(total), .irq(irq));
  rx_source src (.pclk(pclk), .rx_ready(rx_ready), .beat(beat));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // ********
  // checks and bus tasks
  // ********
  task automatic chk(input logic [31:0] got, input logic [63:0] x);
    checked++;
    if (^got === 1'bx || got < x[63:32] || got > x[31:0]) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h..%h", $time, got, x[63:32], x[31:0]);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, lo, hi);
    @(posedge pclk);
    if (!w) expq.push_back({lo, hi});
    req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (rsp.pready !== 1'b1) @(posedge pclk);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] v);
    apb(a, 1'b0, 32'h0, v, v);
  endtask
  task automatic irq_is(input logic v);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, {2{31'h0, v}});
  endtask
  // read data is judged apart from the driver, oldest note first
  always @(posedge pclk) begin
    if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite) chk(rsp.prdata, expq.pop_front());
  end
  task automatic end_of_test;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #80000;
    mismatches++;
    end_of_test;
  end
  // ********
  // scenarios
  // ********
  initial begin
    presetn = 1'b0;
    req = '0;
    total = 32'h3;
    void'($urandom(96));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 'h28; a += 4) rd(8'(a), a == 0 ? 32'h3 : 32'h0);
    rd(8'h40, 32'h0);
    apb(8'h1C, 1'b1, 32'hFFFF_FC00, 32'h0, 32'h0);
    apb(8'h04, 1'b1, 32'h5, 32'h0, 32'h0);
    rd(8'h1C, 32'h0);
    rd(8'h04, 32'h0);
    src.send(2, 2'h0, 6'h0);
    src.idle();
    apb(8'h1C, 1'b1, 32'h1, 32'h0, 32'h0);
    rd(8'h1C, 32'h0);
    src.send(3, 2'h2, 6'h0);
    src.send(1, 2'h0, 6'h04);
    src.send(2, 2'h0, 6'h02);
    src.idle();
    repeat (4) @(posedge pclk);
    rd(8'h04, 32'h1);
    rd(8'h08, 32'h2);
    rd(8'h0C, 32'h16);
    rd(8'h10, 32'h0);
    apb(8'h14, 1'b0, 32'h0, 32'h3, 32'h3);
    rd(8'h18, 32'h0);
    rd(8'h1C, 32'h2C);
    rd(8'h20, 32'h7);
    irq_is(1'b0);
    apb(8'h28, 1'b1, 32'h7, 32'h0, 32'h0);
    irq_is(1'b1);
    rd(8'h28, 32'h7);
    apb(8'h24, 1'b1, 32'h7, 32'h0, 32'h0);
    irq_is(1'b0);
    rd(8'h20, 32'h0);
    apb(8'h1C, 1'b1, 32'h2, 32'h0, 32'h0);
    rd(8'h1C, 32'h2E);
    src.send(1, 2'h0, 6'h0);
    src.idle();
    rd(8'h04, 32'h1);
    apb(8'h14, 1'b0, 32'h0, 32'h3, 32'h3);
    n = $urandom_range(3, 1);
    total <= 32'(n);
    octs = 32'h0;
    apb(8'h1C, 1'b1, 32'h1, 32'h0, 32'h0);
    rd(8'h00, 32'(n));
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h0);
    rd(8'h14, 32'h0);
    rd(8'h1C, 32'h0);
    repeat (n) begin
      b = $urandom_range(4, 1);
      e = $urandom_range(3, 0);
      src.send(b, 2'(e), 6'h0);
      octs += 32'(4 * b - e);
    end
    src.idle();
    repeat (4) @(posedge pclk);
    rd(8'h04, 32'(n));
    rd(8'h0C, octs);
    rd(8'h1C, 32'h4);
    end_of_test;
  end
endmodule
`default_nettype wire
